// [ppvs_defines.svh]
// Timing, raster and limit constants for the panel power and video sequencer
`ifndef PPVS_DEFINES_SVH
`define PPVS_DEFINES_SVH
`define PPVS_CLK_HZ 40000000
`define PPVS_MS_CYC (`PPVS_CLK_HZ / 1000)
`define PPVS_HPD_MAX_MS 200
`define PPVS_BLACK_MAX_MS 200
`define PPVS_SHOW_MAX_MS 50
`define PPVS_BLANK_TYP_MS 64
`define PPVS_END_MAX_MS 500
`define PPVS_OFF_MIN_MS 500
`define PPVS_HPD_MS 20
`define PPVS_CAPS_MS 5
`define PPVS_TRAIN_MS 2
`define PPVS_IDLE_MS 2
`define PPVS_BL_ON_MS 60
`define PPVS_BL_OFF_MS 10
`define PPVS_END_MS 20
`define PPVS_H_TOTAL 4000
`define PPVS_H_ACT 3840
`define PPVS_V_TOTAL 2222
`define PPVS_V_ACT 2160
`define PPVS_NOVID_BIT 3
`define PPVS_DIM_MIN_HZ 200
`define PPVS_DIM_MAX_HZ 10000
`define PPVS_DIM_MIN_CYC (`PPVS_CLK_HZ / `PPVS_DIM_MAX_HZ)
`define PPVS_DIM_MAX_CYC (`PPVS_CLK_HZ / `PPVS_DIM_MIN_HZ)
`define PPVS_DUTY_MIN 5
`define PPVS_DUTY_MAX 100
`endif

// [ppvs_pkg.sv]
// Types shared by both ends of the panel power and video sequencer
package ppvs_pkg;
   typedef enum logic [3:0] {
      SRC_OFF = 4'h0,
      SRC_PWR = 4'h1,
      SRC_CAPS = 4'h3,
      SRC_TRAIN = 4'h2,
      SRC_IDLE = 4'h6,
      SRC_VID = 4'h7,
      SRC_RUN = 4'h5,
      SRC_BLOFF = 4'h4,
      SRC_END = 4'hC,
      SRC_REST = 4'hD
   } ppvs_src_st_t;
   typedef enum logic [1:0] {
      PNL_OFF = 2'h0,
      PNL_BOOT = 2'h1,
      PNL_BLACK = 2'h3,
      PNL_SHOW = 2'h2
   } ppvs_pnl_st_t;
endpackage

// [ppvs_if.sv]
// Link between the video source and the panel
`timescale 1ns/1ps
interface ppvs_if;
   logic panel_logic_supply;
   logic hpd;
   logic aux_req;
   logic aux_ack;
   logic link_train;
   logic link_idle;
   logic vid_de;
   logic [7:0] vbid;
   logic [11:0] msa_hact;
   logic [11:0] msa_vact;
   logic backlight_on;
   logic backlight_dim_pulse;
   logic overdrive_select;
   logic panel_selftest_enable;
   modport source (
      output panel_logic_supply, aux_req, link_train, link_idle, vid_de, vbid,
      output msa_hact, msa_vact, backlight_on, backlight_dim_pulse,
      output overdrive_select, panel_selftest_enable,
      input hpd, aux_ack
   );
   modport panel (
      input panel_logic_supply, aux_req, link_train, link_idle, vid_de, vbid,
      input msa_hact, msa_vact, backlight_on, backlight_dim_pulse,
      input overdrive_select, panel_selftest_enable,
      output hpd, aux_ack
   );
endinterface

// [ppvs_panel.sv]
// Panel end: hot-plug, aux readiness, black video insertion and raster checking
`timescale 1ns/1ps
`include "ppvs_defines.svh"
module ppvs_panel #(
   parameter int MS_CYC = `PPVS_MS_CYC,
   parameter int HPD_MS = `PPVS_HPD_MS,
   parameter int H_TOTAL = `PPVS_H_TOTAL,
   parameter int H_ACT = `PPVS_H_ACT,
   parameter int V_TOTAL = `PPVS_V_TOTAL,
   parameter int V_ACT = `PPVS_V_ACT
) (
   // System
   input wire logic clk,
   input wire logic rstn,
   input wire logic sync_rst,
   // Debug
   input wire logic black_disable,
   // Status
   output logic black_video,
   output logic show_video,
   output logic timing_ok,
   // Link
   ppvs_if.panel lnk
);
   localparam int GAP_LOST = H_TOTAL * (V_TOTAL - V_ACT + 2);
   ppvs_pkg::ppvs_pnl_st_t st_r, st_nxt;
   logic [15:0] tick_r, tick_nxt;
   logic [9:0] ms_r, ms_nxt;
   logic [11:0] h_r, h_nxt, pix_r, pix_nxt, ln_r, ln_nxt, act_r, act_nxt;
   logic [19:0] gap_r, gap_nxt;
   logic de_r, sync_r, sync_nxt, err_r, err_nxt, ok_r, ok_nxt, ack_r, ack_nxt;
   logic tick, rise, fall, fstart, attr_ok, good;

   assign tick = (tick_r == 16'(MS_CYC - 1));
   assign rise = lnk.vid_de & ~de_r;
   assign fall = ~lnk.vid_de & de_r;
   assign fstart = rise & (gap_r >= 20'(H_TOTAL));
   // Stream attributes and link state must match the expected raster
   assign attr_ok = (lnk.msa_hact == 12'(H_ACT)) && (lnk.msa_vact == 12'(V_ACT))
      && !lnk.link_train && !lnk.link_idle;
   // Flag in VB-ID stops video at once, ahead of any timing verdict
   assign good = ok_r && attr_ok && !lnk.vbid[`PPVS_NOVID_BIT];

   always_comb begin
      st_nxt = st_r;
      tick_nxt = tick ? 16'h0000 : tick_r + 16'h0001;
      ms_nxt = (tick && ms_r != 10'h3FF) ? ms_r + 10'h001 : ms_r;
      ack_nxt = 1'b0;
      unique case (st_r)
         ppvs_pkg::PNL_OFF: begin
            tick_nxt = 16'h0000;
            ms_nxt = 10'h000;
            if (lnk.panel_logic_supply) begin
               st_nxt = ppvs_pkg::PNL_BOOT;
            end
         end
         ppvs_pkg::PNL_BOOT: begin
            // Aux is served from here on, so hpd never precedes readiness
            if (ms_r >= 10'(HPD_MS) || ms_r >= 10'(`PPVS_HPD_MAX_MS)) begin
               st_nxt = ppvs_pkg::PNL_BLACK;
            end
         end
         ppvs_pkg::PNL_BLACK: begin
            if (good) begin
               st_nxt = ppvs_pkg::PNL_SHOW;
            end
         end
         ppvs_pkg::PNL_SHOW: begin
            if (!good) begin
               st_nxt = ppvs_pkg::PNL_BLACK;
            end
         end
      endcase
      if (st_r != ppvs_pkg::PNL_OFF) begin
         ack_nxt = lnk.aux_req & ~ack_r;
      end
      if (!lnk.panel_logic_supply || sync_rst) begin
         st_nxt = ppvs_pkg::PNL_OFF;
         ack_nxt = 1'b0;
      end
   end

   always_comb begin
      h_nxt = (rise || h_r == 12'(H_TOTAL - 1)) ? 12'h000 : h_r + 12'h001;
      pix_nxt = lnk.vid_de ? pix_r + 12'h001 : 12'h000;
      gap_nxt = lnk.vid_de ? 20'h00000 : (gap_r >= 20'(GAP_LOST) ? gap_r : gap_r + 20'h00001);
      ln_nxt = (h_r == 12'(H_TOTAL - 1)) ? ln_r + 12'h001 : ln_r;
      act_nxt = rise ? act_r + 12'h001 : act_r;
      sync_nxt = sync_r;
      err_nxt = err_r;
      ok_nxt = ok_r;
      // Active width checked on every line; line period only once in frame sync
      if ((rise && sync_r && h_r != 12'(H_TOTAL - 1)) || (fall && pix_r != 12'(H_ACT))) begin
         err_nxt = 1'b1;
         ok_nxt = 1'b0;
      end
      if (fstart) begin
         // A line error on this very edge still spoils the frame that it closes
         ok_nxt = sync_r && !err_nxt && ln_r == 12'(V_TOTAL - 1)
            && act_r == 12'(V_ACT);
         sync_nxt = 1'b1;
         err_nxt = 1'b0;
         ln_nxt = 12'h000;
         act_nxt = 12'h001;
      end
      // Main link gone quiet for longer than a vertical blank
      if (gap_r >= 20'(GAP_LOST) || st_r == ppvs_pkg::PNL_OFF) begin
         ok_nxt = 1'b0;
         sync_nxt = 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         st_r <= ppvs_pkg::PNL_OFF;
         tick_r <= 16'h0000;
         ms_r <= 10'h000;
         ack_r <= 1'b0;
         de_r <= 1'b0;
         h_r <= 12'h000;
         pix_r <= 12'h000;
         gap_r <= 20'h00000;
         ln_r <= 12'h000;
         act_r <= 12'h000;
         sync_r <= 1'b0;
         err_r <= 1'b0;
         ok_r <= 1'b0;
      end else begin
         st_r <= st_nxt;
         tick_r <= tick_nxt;
         ms_r <= ms_nxt;
         ack_r <= ack_nxt;
         de_r <= lnk.vid_de;
         h_r <= h_nxt;
         pix_r <= pix_nxt;
         gap_r <= gap_nxt;
         ln_r <= ln_nxt;
         act_r <= act_nxt;
         sync_r <= sync_nxt;
         err_r <= err_nxt;
         ok_r <= ok_nxt;
      end
   end

   assign lnk.hpd = (st_r == ppvs_pkg::PNL_BLACK) || (st_r == ppvs_pkg::PNL_SHOW);
   assign lnk.aux_ack = ack_r;
   // Black from the first cycle of supply; debug switch bypasses insertion
   assign black_video = (st_r != ppvs_pkg::PNL_SHOW) && !black_disable;
   assign show_video = (st_r != ppvs_pkg::PNL_OFF) && !black_video;
   assign timing_ok = ok_r;
endmodule

// [ppvs_source.sv]
// Source end: panel power, link bring-up, video raster, backlight ordering and dimming
`timescale 1ns/1ps
`include "ppvs_defines.svh"
module ppvs_source #(
   parameter int MS_CYC = `PPVS_MS_CYC,
   parameter int CAPS_MS = `PPVS_CAPS_MS,
   parameter int TRAIN_MS = `PPVS_TRAIN_MS,
   parameter int IDLE_MS = `PPVS_IDLE_MS,
   parameter int BL_ON_MS = `PPVS_BL_ON_MS,
   parameter int BL_OFF_MS = `PPVS_BL_OFF_MS,
   parameter int END_MS = `PPVS_END_MS,
   parameter int OFF_MS = `PPVS_OFF_MIN_MS,
   parameter int H_TOTAL = `PPVS_H_TOTAL,
   parameter int H_ACT = `PPVS_H_ACT,
   parameter int V_TOTAL = `PPVS_V_TOTAL,
   parameter int V_ACT = `PPVS_V_ACT
) (
   // System
   input wire logic clk,
   input wire logic rstn,
   input wire logic sync_rst,
   // User control
   input wire logic power_req,
   input wire logic od_req,
   input wire logic psr_req,
   input wire logic selftest_req,
   input wire logic [17:0] dim_period,
   input wire logic [6:0] dim_duty,
   // Status
   output logic powered,
   output logic video_on,
   output logic off_done,
   // Link
   ppvs_if.source lnk
);
   ppvs_pkg::ppvs_src_st_t st_r, st_nxt;
   logic [15:0] tick_r, tick_nxt;
   logic [9:0] ms_r, ms_nxt;
   logic caps_r, caps_nxt, req_r, req_nxt;
   logic [11:0] h_r, h_nxt, v_r, v_nxt;
   logic de_r, de_nxt, send;
   logic [17:0] dcnt_r, dcnt_nxt, per;
   logic [24:0] on_cyc;
   logic dim_r, dim_nxt;
   logic od_r, od_nxt, st_en_r, st_en_nxt;
   logic tick;

   // Clamp a value into [lo, hi]
   function automatic logic [17:0] clamp18(input logic [17:0] x, input logic [17:0] lo,
                                            input logic [17:0] hi);
      clamp18 = (x < lo) ? lo : ((x > hi) ? hi : x);
   endfunction

   // Elapsed milliseconds in the current state reached the limit
   function automatic logic ms_done(input logic [9:0] ms, input int lim);
      ms_done = (ms >= 10'(lim));
   endfunction

   assign tick = (tick_r == 16'(MS_CYC - 1));
   assign send = (st_r == ppvs_pkg::SRC_VID) || (st_r == ppvs_pkg::SRC_RUN)
      || (st_r == ppvs_pkg::SRC_BLOFF);

   always_comb begin
      st_nxt = st_r;
      caps_nxt = caps_r;
      req_nxt = 1'b0;
      unique case (st_r)
         ppvs_pkg::SRC_OFF: begin
            caps_nxt = 1'b0;
            if (power_req) begin
               st_nxt = ppvs_pkg::SRC_PWR;
            end
         end
         ppvs_pkg::SRC_PWR: begin
            // Early polling is allowed; unanswered requests are simply repeated
            req_nxt = !lnk.aux_ack;
            if (lnk.hpd) begin
               st_nxt = ppvs_pkg::SRC_CAPS;
            end
         end
         ppvs_pkg::SRC_CAPS: begin
            if (lnk.aux_ack) begin
               caps_nxt = 1'b1;
            end
            req_nxt = !caps_r && !lnk.aux_ack;
            if (caps_r && ms_done(ms_r, CAPS_MS)) begin
               st_nxt = ppvs_pkg::SRC_TRAIN;
            end
         end
         ppvs_pkg::SRC_TRAIN: begin
            if (ms_done(ms_r, TRAIN_MS)) begin
               st_nxt = ppvs_pkg::SRC_IDLE;
            end
         end
         ppvs_pkg::SRC_IDLE: begin
            if (ms_done(ms_r, IDLE_MS)) begin
               st_nxt = ppvs_pkg::SRC_VID;
            end
         end
         ppvs_pkg::SRC_VID: begin
            if (ms_done(ms_r, BL_ON_MS)) begin
               st_nxt = ppvs_pkg::SRC_RUN;
            end
         end
         ppvs_pkg::SRC_RUN: begin
            if (!power_req) begin
               st_nxt = ppvs_pkg::SRC_BLOFF;
            end
         end
         ppvs_pkg::SRC_BLOFF: begin
            // Video keeps flowing until the backlight has had time to go dark
            if (ms_done(ms_r, BL_OFF_MS)) begin
               st_nxt = ppvs_pkg::SRC_END;
            end
         end
         ppvs_pkg::SRC_END: begin
            if (ms_done(ms_r, END_MS) || ms_done(ms_r, `PPVS_END_MAX_MS)) begin
               st_nxt = ppvs_pkg::SRC_REST;
            end
         end
         ppvs_pkg::SRC_REST: begin
            if (ms_done(ms_r, OFF_MS)) begin
               st_nxt = ppvs_pkg::SRC_OFF;
            end
         end
         default: begin
            st_nxt = ppvs_pkg::SRC_OFF;
         end
      endcase
      // Power drop before the backlight came on skips straight to the end
      if (!power_req && (st_r == ppvs_pkg::SRC_PWR || st_r == ppvs_pkg::SRC_CAPS
          || st_r == ppvs_pkg::SRC_TRAIN || st_r == ppvs_pkg::SRC_IDLE
          || st_r == ppvs_pkg::SRC_VID)) begin
         st_nxt = ppvs_pkg::SRC_END;
      end
      if (sync_rst) begin
         st_nxt = ppvs_pkg::SRC_OFF;
         req_nxt = 1'b0;
      end
      tick_nxt = (tick || st_nxt != st_r) ? 16'h0000 : tick_r + 16'h0001;
      if (st_nxt != st_r) begin
         ms_nxt = 10'h000;
      end else begin
         ms_nxt = (tick && ms_r != 10'h3FF) ? ms_r + 10'h001 : ms_r;
      end
   end

   // Raster generator, data-enable only
   always_comb begin
      h_nxt = 12'h000;
      v_nxt = 12'h000;
      if (send) begin
         h_nxt = (h_r == 12'(H_TOTAL - 1)) ? 12'h000 : h_r + 12'h001;
         v_nxt = v_r;
         if (h_r == 12'(H_TOTAL - 1)) begin
            v_nxt = (v_r == 12'(V_TOTAL - 1)) ? 12'h000 : v_r + 12'h001;
         end
      end
      de_nxt = (st_nxt == ppvs_pkg::SRC_VID || st_nxt == ppvs_pkg::SRC_RUN
         || st_nxt == ppvs_pkg::SRC_BLOFF) && (h_nxt < 12'(H_ACT)) && (v_nxt < 12'(V_ACT));
   end

   // Dimming pulse; out-of-range settings are pulled into the legal window
   always_comb begin
      per = clamp18(dim_period, 18'(`PPVS_DIM_MIN_CYC), 18'(`PPVS_DIM_MAX_CYC));
      on_cyc = 25'((25'(per) * 25'(clamp18(18'(dim_duty), 18'(`PPVS_DUTY_MIN),
         18'(`PPVS_DUTY_MAX)))) / 25'd100);
      dcnt_nxt = (dcnt_r >= per - 18'h00001) ? 18'h00000 : dcnt_r + 18'h00001;
      dim_nxt = (st_nxt == ppvs_pkg::SRC_RUN) && (25'(dcnt_nxt) < on_cyc);
      // Overdrive held low unless asked for, and never alongside self refresh
      od_nxt = od_req && !psr_req && (st_nxt != ppvs_pkg::SRC_OFF)
         && (st_nxt != ppvs_pkg::SRC_REST);
      st_en_nxt = selftest_req && (st_nxt != ppvs_pkg::SRC_OFF)
         && (st_nxt != ppvs_pkg::SRC_REST);
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         st_r <= ppvs_pkg::SRC_OFF;
         tick_r <= 16'h0000;
         ms_r <= 10'h000;
         caps_r <= 1'b0;
         req_r <= 1'b0;
         h_r <= 12'h000;
         v_r <= 12'h000;
         de_r <= 1'b0;
         dcnt_r <= 18'h00000;
         dim_r <= 1'b0;
         od_r <= 1'b0;
         st_en_r <= 1'b0;
      end else begin
         st_r <= st_nxt;
         tick_r <= tick_nxt;
         ms_r <= ms_nxt;
         caps_r <= caps_nxt;
         req_r <= req_nxt;
         h_r <= h_nxt;
         v_r <= v_nxt;
         de_r <= de_nxt;
         dcnt_r <= dcnt_nxt;
         dim_r <= dim_nxt;
         od_r <= od_nxt;
         st_en_r <= st_en_nxt;
      end
   end

   // Every pin toward the panel is low whenever its supply is off
   assign lnk.panel_logic_supply = (st_r != ppvs_pkg::SRC_OFF) && (st_r != ppvs_pkg::SRC_REST);
   assign lnk.aux_req = req_r;
   assign lnk.link_train = (st_r == ppvs_pkg::SRC_TRAIN);
   assign lnk.link_idle = (st_r == ppvs_pkg::SRC_IDLE);
   assign lnk.vid_de = de_r;
   // No-video flag marks every on-state without a stream
   assign lnk.vbid = {4'h0, lnk.panel_logic_supply && !send, 3'h0};
   assign lnk.msa_hact = send ? 12'(H_ACT) : 12'h000;
   assign lnk.msa_vact = send ? 12'(V_ACT) : 12'h000;
   assign lnk.backlight_on = (st_r == ppvs_pkg::SRC_RUN);
   assign lnk.backlight_dim_pulse = dim_r;
   assign lnk.overdrive_select = od_r;
   assign lnk.panel_selftest_enable = st_en_r;
   assign powered = lnk.panel_logic_supply;
   assign video_on = send;
   assign off_done = (st_r == ppvs_pkg::SRC_OFF);
endmodule

// [ppvs_assertions.sv]
// Concurrent checks on the link between the source and panel ends
`timescale 1ns/1ps
module ppvs_assertions #(
   parameter int MS_CYC = 20,
   parameter int HPD_MS = 2,
   parameter int END_MS = 3,
   parameter int H_ACT = 16
) (
   // System
   input wire logic clk,
   input wire logic rstn,
   input wire logic sync_rst,
   // Status and debug
   input wire logic black_disable,
   input wire logic black_video,
   input wire logic show_video,
   input wire logic video_on,
   // Link
   input wire logic panel_logic_supply,
   input wire logic hpd,
   input wire logic aux_req,
   input wire logic aux_ack,
   input wire logic link_train,
   input wire logic link_idle,
   input wire logic vid_de,
   input wire logic [7:0] vbid,
   input wire logic backlight_on,
   input wire logic backlight_dim_pulse,
   input wire logic overdrive_select,
   input wire logic panel_selftest_enable
);
   localparam int HPD_LIM = HPD_MS * MS_CYC + 4;
   localparam int SHOW_LIM = 50 * MS_CYC;
   localparam int END_LIM = END_MS * MS_CYC + 4;
   localparam int BLANK_LIM = 64 * MS_CYC;
   logic [15:0] lo_cnt_r;
   logic [15:0] de_hi_r;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   // Run lengths of DE; the low count saturates so it cannot wrap back under the limit
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         lo_cnt_r <= 16'h0000;
         de_hi_r <= 16'h0000;
      end else begin
         lo_cnt_r <= vid_de ? 16'h0000 :
            ((lo_cnt_r == 16'(BLANK_LIM)) ? lo_cnt_r : lo_cnt_r + 16'h0001);
         de_hi_r <= vid_de ? de_hi_r + 16'h0001 : 16'h0000;
      end
   end
   chk_hpd_deadline: assert property ($rose(panel_logic_supply) |-> ##[1:HPD_LIM] hpd)
      else $error("hot plug late after supply rise");
   chk_hpd_unpowered: assert property (!panel_logic_supply [*2] |-> !hpd)
      else $error("hot plug high without supply");
   chk_aux_answer: assert property (aux_ack |-> $past(aux_req) && $past(panel_logic_supply))
      else $error("aux answer without request");
   chk_flag_black: assert property (vbid[3] && !black_disable |=> black_video || black_disable)
      else $error("no-video flag did not force black");
   chk_show_deadline: assert property ($rose(video_on) |-> ##[1:SHOW_LIM] show_video)
      else $error("video not shown in time");
   chk_blank_loss: assert property (lo_cnt_r == 16'(BLANK_LIM) && !black_disable |-> black_video)
      else $error("missing video not blacked");
   chk_bl_stable: assert property ($rose(backlight_on) |-> show_video && video_on)
      else $error("backlight on before stable video");
   chk_bl_off_first: assert property ($fell(video_on) && !$past(sync_rst) |-> !$past(backlight_on, 2))
      else $error("video ended with backlight lit");
   chk_supply_off: assert property ($fell(video_on) |-> ##[0:END_LIM] !panel_logic_supply)
      else $error("supply not removed after video end");
   chk_train_after_hpd: assert property ($rose(link_train) |-> hpd && $past(hpd, 8))
      else $error("training started too soon");
   chk_idle_before: assert property ($rose(video_on) |-> $past(link_idle) && $past(link_idle, 20))
      else $error("video without idle pattern");
   chk_line_width: assert property ($fell(vid_de) && backlight_on |-> de_hi_r == 16'(H_ACT))
      else $error("active line width wrong");
   chk_unpowered_low: assert property (!panel_logic_supply [*3] |-> !backlight_on && !vid_de &&
      !backlight_dim_pulse && !aux_req && !link_train && !link_idle && !overdrive_select &&
      !panel_selftest_enable && vbid == 8'h00)
      else $error("link signal high without supply");
endmodule

// [test_panel_power_video_sequencer.sv]
// Self-checking bench joining the source and panel ends
`timescale 1ns/1ps
`include "ppvs_defines.svh"
module test_panel_power_video_sequencer;
   localparam int MS = 20;
   localparam int HPD = 2;
   localparam int HT = 20;
   localparam int HA = 16;
   localparam int VT = 12;
   localparam int VA = 8;
   localparam int ENDM = 3;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic sync_rst = 1'b0;
   logic power_req = 1'b0;
   logic od_req = 1'b0;
   logic psr_req = 1'b0;
   logic selftest_req = 1'b0;
   logic black_disable = 1'b0;
   logic [17:0] dim_period = 18'h00FA0;
   logic [6:0] dim_duty = 7'h32;
   logic powered, video_on, off_done, black_video, show_video, timing_ok;
   int fails = 0;
   int comparisons = 0;
   integer seed = 32'hD416;
   int n;
   int p;
   int hi;
   int per_q[$];
   int duty_q[$];
   ppvs_if link();
   ppvs_source #(.MS_CYC(MS), .CAPS_MS(2), .TRAIN_MS(1), .IDLE_MS(2), .BL_ON_MS(60),
      .BL_OFF_MS(2), .END_MS(ENDM), .OFF_MS(2), .H_TOTAL(HT), .H_ACT(HA), .V_TOTAL(VT),
      .V_ACT(VA)) i_ppvs_source (.clk(clk), .rstn(rstn), .sync_rst(sync_rst),
      .power_req(power_req), .od_req(od_req), .psr_req(psr_req), .selftest_req(selftest_req),
      .dim_period(dim_period), .dim_duty(dim_duty), .powered(powered), .video_on(video_on),
      .off_done(off_done), .lnk(link));
   ppvs_panel #(.MS_CYC(MS), .HPD_MS(HPD), .H_TOTAL(HT), .H_ACT(HA), .V_TOTAL(VT),
      .V_ACT(VA)) i_ppvs_panel (.clk(clk), .rstn(rstn), .sync_rst(sync_rst),
      .black_disable(black_disable), .black_video(black_video), .show_video(show_video),
      .timing_ok(timing_ok), .lnk(link));
   ppvs_assertions #(.MS_CYC(MS), .HPD_MS(HPD), .END_MS(ENDM), .H_ACT(HA)) i_ppvs_assertions (
      .clk(clk), .rstn(rstn), .sync_rst(sync_rst), .black_disable(black_disable),
      .black_video(black_video), .show_video(show_video), .video_on(video_on),
      .panel_logic_supply(link.panel_logic_supply), .hpd(link.hpd), .aux_req(link.aux_req),
      .aux_ack(link.aux_ack), .link_train(link.link_train), .link_idle(link.link_idle),
      .vid_de(link.vid_de), .vbid(link.vbid), .backlight_on(link.backlight_on),
      .backlight_dim_pulse(link.backlight_dim_pulse),
      .overdrive_select(link.overdrive_select),
      .panel_selftest_enable(link.panel_selftest_enable));
   initial begin
      forever #12.5 clk = ~clk;
   end
   task automatic tick(input int k);
      repeat (k) @(posedge clk);
      #2;
   endtask
   task automatic chk(input logic [31:0] exp, input logic [31:0] act);
      comparisons++;
      if (act !== exp) begin
         fails++;
         $display("CHECK FAILED at %0t: expected %0h got %0h", $time, exp, act);
      end
   endtask
   task automatic chk1(input logic exp, input logic act);
      chk(32'(exp), 32'(act));
   endtask
   // Selector: 0 hpd, 1 aux_ack, 2 video_on, 3 show, 4 backlight, 5 powered, 6 off_done,
   // 7 data enable, 8 dimming pulse
   function automatic logic sig(input int sel);
      case (sel)
         0: return link.hpd;
         1: return link.aux_ack;
         2: return video_on;
         3: return show_video;
         4: return link.backlight_on;
         5: return powered;
         6: return off_done;
         7: return link.vid_de;
         8: return link.backlight_dim_pulse;
         default: return 1'bx;
      endcase
   endfunction
   // A wait that runs out shows up as a mismatch on the awaited level
   task automatic wait_for(input int sel, input logic val, input int lim, output int cyc);
      cyc = 0;
      while (sig(sel) !== val && cyc < lim) begin
         tick(1);
         cyc++;
      end
      chk1(val, sig(sel));
   endtask
   // Any window one period long holds the same high count, so no phase lock is needed
   task automatic count_hi(input int sel, input int len, output int highs, output int rises);
      logic prev;
      highs = 0;
      rises = 0;
      prev = sig(sel);
      repeat (len) begin
         tick(1);
         if (sig(sel) === 1'b1) highs++;
         if (sig(sel) === 1'b1 && prev === 1'b0) rises++;
         prev = sig(sel);
      end
   endtask
   task automatic model(input int per, input int duty, output int pp, output int hh);
      int dd;
      pp = per < `PPVS_DIM_MIN_CYC ? `PPVS_DIM_MIN_CYC : per;
      pp = pp > `PPVS_DIM_MAX_CYC ? `PPVS_DIM_MAX_CYC : pp;
      dd = duty < `PPVS_DUTY_MIN ? `PPVS_DUTY_MIN : duty;
      dd = dd > `PPVS_DUTY_MAX ? `PPVS_DUTY_MAX : dd;
      hh = pp * dd / 100;
   endtask
   task automatic test_done();
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   initial begin
      repeat (80000) @(posedge clk);
      fails++;
      test_done();
   end
   initial begin
      tick(12);
      chk1(1'b1, off_done);
      chk1(1'b0, link.hpd);
      chk1(1'b1, black_video);
      chk1(1'b0, link.backlight_on);
      rstn = 1'b1;
      $display("test reset done");
      n = $random(seed);
      psr_req = n[0];
      od_req = n[1];
      selftest_req = n[2];
      power_req = 1'b1;
      wait_for(1, 1'b1, HPD * MS + 4, n);
      wait_for(0, 1'b1, HPD * MS + 4, n);
      chk1(1'b1, black_video);
      n = $random(seed);
      black_disable = n[3];
      tick(1);
      chk1(~n[3], black_video);
      chk1(n[3], show_video);
      black_disable = 1'b0;
      tick(1);
      chk1(1'b1, black_video);
      $display("test hot plug done");
      wait_for(2, 1'b1, 400, n);
      wait_for(3, 1'b1, 50 * MS, n);
      chk1(1'b1, timing_ok);
      count_hi(7, HT * VT, hi, n);
      chk(VA, n);
      chk(VA * HA, hi);
      $display("test video done");
      wait_for(4, 1'b1, 60 * MS + 4, n);
      chk1(1'b1, show_video);
      chk1(od_req & ~psr_req, link.overdrive_select);
      chk1(selftest_req, link.panel_selftest_enable);
      $display("test backlight done");
      per_q.push_back(100);
      duty_q.push_back(2);
      n = $random(seed);
      per_q.push_back(4000 + (n & 1023));
      duty_q.push_back(100);
      n = $random(seed);
      per_q.push_back(4000 + (n & 1023));
      duty_q.push_back(5 + ((n >> 12) & 63));
      foreach (per_q[i]) begin
         dim_period = 18'(per_q[i]);
         dim_duty = 7'(duty_q[i]);
         model(per_q[i], duty_q[i], p, hi);
         tick(10200);
         count_hi(8, p, n, p);
         chk(hi, n);
      end
      $display("test dimming done");
      power_req = 1'b0;
      wait_for(4, 1'b0, 4, n);
      chk1(1'b1, video_on);
      wait_for(2, 1'b0, 2 * MS + 4, n);
      tick(2);
      chk1(1'b1, link.vbid[3]);
      chk1(1'b1, black_video);
      wait_for(5, 1'b0, ENDM * MS + 4, n);
      wait_for(6, 1'b1, 2 * MS + 4, n);
      chk1(1'b0, link.hpd);
      $display("test power down done");
      power_req = 1'b1;
      wait_for(0, 1'b1, HPD * MS + 4, n);
      power_req = 1'b0;
      sync_rst = 1'b1;
      tick(1);
      sync_rst = 1'b0;
      tick(1);
      chk1(1'b1, off_done);
      chk1(1'b0, link.hpd);
      chk1(1'b0, powered);
      chk1(1'b1, black_video);
      tick(64 * MS + 4);
      chk1(1'b1, black_video);
      $display("test sync reset done");
      test_done();
   end
endmodule
